// ===== inc/ppid_pkg.sv
// constants, register map and carrier types of the process regulator
package ppid_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_PERIOD_US = 2000;
   localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int TICK_MS = TICK_PERIOD_US / 1000;
   localparam int STEPS_PER_CS = 10000 / TICK_PERIOD_US;
   // scaling: percent in 0.1 %, fine percent in 0.01 %, gain in 0.1
   localparam int PCT_FULL = 1000;
   localparam int FINE_FULL = 10000;
   localparam int GAIN_FULL = 1000;
   localparam int RAMP_Q = 16;
   localparam int OUT_Q = 8;
   localparam int W_Q = 8;
   localparam int ACC_LIM = 32'h3fffffff;
   localparam int OPT_BASE = 10;
   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_DIR = 6'h00;
   localparam logic [5:0] IDX_FULL_SCALE = 6'h01;
   localparam logic [5:0] IDX_KP1 = 6'h02;
   localparam logic [5:0] IDX_TI1 = 6'h03;
   localparam logic [5:0] IDX_TD1 = 6'h04;
   localparam logic [5:0] IDX_REV_CUT = 6'h05;
   localparam logic [5:0] IDX_DEAD = 6'h06;
   localparam logic [5:0] IDX_DCLAMP = 6'h07;
   localparam logic [5:0] IDX_RAMP = 6'h08;
   localparam logic [5:0] IDX_FB_FILT = 6'h09;
   localparam logic [5:0] IDX_OUT_FILT = 6'h0a;
   localparam logic [5:0] IDX_KP2 = 6'h0b;
   localparam logic [5:0] IDX_TI2 = 6'h0c;
   localparam logic [5:0] IDX_TD2 = 6'h0d;
   localparam logic [5:0] IDX_POLICY = 6'h0e;
   localparam logic [5:0] IDX_TH_LO = 6'h0f;
   localparam logic [5:0] IDX_TH_HI = 6'h10;
   localparam logic [5:0] IDX_INIT = 6'h11;
   localparam logic [5:0] IDX_HOLD = 6'h12;
   localparam logic [5:0] IDX_RISE = 6'h13;
   localparam logic [5:0] IDX_FALL = 6'h14;
   localparam logic [5:0] IDX_OPT = 6'h15;
   localparam logic [5:0] IDX_MAXF = 6'h16;
   localparam logic [5:0] IDX_OUT = 6'h17;
   localparam logic [5:0] IDX_SP_DISP = 6'h18;
   localparam logic [5:0] IDX_FB_DISP = 6'h19;
   localparam logic [5:0] IDX_FLAGS = 6'h1a;
   localparam int NUM_RW = 23;
   // reset values
   localparam logic [15:0] RST_FULL_SCALE = 16'h03e8;
   localparam logic [15:0] RST_GAIN = 16'h00c8;
   localparam logic [15:0] RST_TI = 16'h00c8;
   localparam logic [15:0] RST_REV_CUT = 16'h00c8;
   localparam logic [15:0] RST_DCLAMP = 16'h000a;
   localparam logic [15:0] RST_TH_LO = 16'h00c8;
   localparam logic [15:0] RST_TH_HI = 16'h0320;
   localparam logic [15:0] RST_SLEW = 16'h0064;
   localparam logic [15:0] RST_MAXF = 16'h1388;
   localparam logic [NUM_RW-1:0][15:0] REG_RST = {
      RST_MAXF, 16'h0000, RST_SLEW, RST_SLEW, 16'h0000, 16'h0000,
      RST_TH_HI, RST_TH_LO, 16'h0000, 16'h0000, RST_TI, RST_GAIN,
      16'h0000, 16'h0000, 16'h0000, RST_DCLAMP, 16'h0000, RST_REV_CUT,
      16'h0000, RST_TI, RST_GAIN, RST_FULL_SCALE, 16'h0000};

   typedef enum logic [1:0] {
      PPID_SW_NONE, PPID_SW_DI, PPID_SW_AUTO
   } ppid_switch_e;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } ppid_avs_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } ppid_avs_rsp_s;

   typedef struct packed {
      logic run;
      logic di_invert;
      logic di_gain_sel;
      logic di_int_pause;
      logic [15:0] setpoint;
      logic [15:0] feedback;
   } ppid_proc_s;

   typedef struct packed {
      logic [NUM_RW-1:0][15:0] regs;
      logic ack;
      logic [31:0] rdata;
      logic [19:0] tick_cnt;
      logic run_prev;
      logic holding;
      logic [19:0] hold_cnt;
      logic [31:0] sp_r;
      logic signed [31:0] fb_f;
      logic [15:0] fb_prev;
      logic signed [31:0] acc;
      logic signed [31:0] out_raw;
      logic signed [31:0] out_f;
      logic sat;
      logic [15:0] sp_disp;
      logic [15:0] fb_disp;
   } ppid_state_s;

   localparam ppid_state_s ST_RST = '{regs: REG_RST, default: '0};
endpackage

// ===== logic/ppid_regulator.sv
// process regulator turning setpoint and feedback into a frequency reference
//
// Operation
// - forward action raises output when feedback low
// - setpoint and feedback relative 0..100 %, equalised
// - reverse action lowers output when feedback low
// - inversion input swaps the action direction
// - displays scale 100 % to full-scale value
// - gain 100.0 at 100 % gives maximum frequency
// - 100 % held integral time gives maximum frequency
// - 100 % change in derivative time gives maximum
// - negative output limited to reverse cut-off
// - inside dead band output holds steady
// - derivative term clamped to differential limit
// - setpoint ramps linearly, full span in ramp time
// - feedback passes a configurable low-pass filter
// - output passes its own low-pass filter
// - gain switchover: none, input, or by deviation
// - switch input off selects set one, on two
// - automatic switch interpolates between both thresholds
// - start-up forces initial value for hold time
// - pause input freezes integrator when separation on
// - separation off keeps integrator running despite the pause input
// - tens digit chooses stop integrating at limit
// - stop-at-limit freezes integrator while saturated
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module ppid_regulator #(
   parameter int TICK_CYCLES_P = ppid_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register slave
   input wire ppid_pkg::ppid_avs_req_s avs_req_i,
   output ppid_pkg::ppid_avs_rsp_s avs_rsp_o,
   // process side
   input wire ppid_pkg::ppid_proc_s proc_i,
   // results
   output logic signed [31:0] freq_ref_o,
   output logic [15:0] setpoint_display_value_o,
   output logic [15:0] feedback_display_value_o
);
   import ppid_pkg::*;

   ppid_state_s st_ff;
   ppid_state_s nxt_st;
   ppid_switch_e pol;
   logic tick, rdir, hit, live, dead, freeze, sat_nx, hold_end;
   logic opt_sep, opt_stop;
   logic [5:0] idx;
   logic [31:0] rd_word, status;
   logic signed [63:0] maxf, sp_tgt, sp_cur, step, sp_up, sp_dn, sp_nx;
   logic signed [63:0] fb_in, fb_nx, sp_v, fb_v, err, abse, lo, hi;
   logic signed [63:0] w_auto, w, kp, ti, td, p_t, acc_sum, acc_nx, i_t;
   logic signed [63:0] dch, d_raw, dlim, d_t, u, rc, u_sat, init, prev;
   logic signed [63:0] rl, fl, slw, hlim;
   logic signed [31:0] of_nx;

   ////////////////////////////////////////////////////////////////////////
   // arithmetic helpers

   function automatic logic signed [63:0] s64(input logic [31:0] v);
      return $signed({32'h0, v});
   endfunction

   function automatic logic signed [63:0] sx(input logic signed [31:0] v);
      return {{32{v[31]}}, v};
   endfunction

   function automatic logic signed [63:0] rg(input logic [5:0] i);
      return s64({16'h0, st_ff.regs[i]});
   endfunction

   function automatic logic signed [63:0] pct(input logic [15:0] v);
      return (v > 16'(PCT_FULL)) ? s64(32'(PCT_FULL)) : s64({16'h0, v});
   endfunction

   // first-order lag, tau in 0.01 s; a zero tau passes straight through
   function automatic logic signed [31:0] lpf(
      input logic signed [31:0] y,
      input logic signed [63:0] x,
      input logic [15:0] tau
   );
      logic signed [63:0] den;
      logic signed [63:0] q;
      den = s64({16'h0, tau}) * s64(32'(STEPS_PER_CS)) + 64'sd1;
      q = (x - sx(y)) / den;
      return 32'(sx(y) + q);
   endfunction

   function automatic logic signed [63:0] mix(
      input logic signed [63:0] a,
      input logic signed [63:0] b,
      input logic signed [63:0] wt
   );
      return a + (((b - a) * wt) >>> W_Q);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register slave: one wait state, read data captured from flip-flops

   assign idx = avs_req_i.address[7:2];
   assign hit = (avs_req_i.address[1:0] == 2'h0) && (idx <= IDX_FLAGS);
   assign status = (idx == IDX_OUT) ? freq_ref_o :
                   (idx == IDX_SP_DISP) ? {16'h0, st_ff.sp_disp} :
                   (idx == IDX_FB_DISP) ? {16'h0, st_ff.fb_disp} :
                   {29'h0, st_ff.holding, st_ff.sat, proc_i.run};
   // unmapped or misaligned addresses read zero and ignore writes
   assign rd_word = !hit ? 32'h0 :
                    (idx < 6'(NUM_RW)) ? {16'h0, st_ff.regs[idx]} : status;
   assign avs_rsp_o = '{readdata: st_ff.rdata,
                        waitrequest: (avs_req_i.read | avs_req_i.write)
                                     & ~st_ff.ack};

   ////////////////////////////////////////////////////////////////////////
   // control path

   assign tick = st_ff.tick_cnt == 20'(TICK_CYCLES_P - 1);
   assign live = tick & proc_i.run & st_ff.run_prev & ~st_ff.holding;
   assign maxf = rg(IDX_MAXF);

   assign sp_tgt = pct(proc_i.setpoint) <<< RAMP_Q;
   assign sp_cur = s64(st_ff.sp_r);
   assign step = (s64(32'(PCT_FULL)) <<< RAMP_Q)
                 / ((rg(IDX_RAMP) * STEPS_PER_CS) | 64'sd1);
   assign sp_up = sp_cur + step;
   assign sp_dn = sp_cur - step;
   assign sp_nx = (rg(IDX_RAMP) == 64'sd0) ? sp_tgt :
                  (sp_cur < sp_tgt) ? ((sp_up > sp_tgt) ? sp_tgt : sp_up)
                  : ((sp_dn < sp_tgt) ? sp_tgt : sp_dn);
   assign fb_in = pct(proc_i.feedback) <<< RAMP_Q;
   assign fb_nx = sx(lpf(st_ff.fb_f, fb_in, st_ff.regs[IDX_FB_FILT]));
   assign sp_v = sp_nx >>> RAMP_Q;
   assign fb_v = fb_nx >>> RAMP_Q;

   // forward acts on setpoint minus feedback, reverse on the opposite
   assign rdir = st_ff.regs[IDX_DIR][0] ^ proc_i.di_invert;
   assign err = rdir ? (fb_v - sp_v) : (sp_v - fb_v);
   assign abse = (err < 0) ? -err : err;

   // gain set weight, 0 is set one and one in W_Q is set two
   assign pol = ppid_switch_e'(st_ff.regs[IDX_POLICY][1:0]);
   assign lo = rg(IDX_TH_LO);
   assign hi = rg(IDX_TH_HI);
   // the division runs only with lo < abse < hi, so hi - lo is positive
   assign w_auto = (abse <= lo) ? 64'sd0 :
                   (abse >= hi) ? (64'sd1 <<< W_Q) :
                   ((abse - lo) <<< W_Q) / ((hi - lo) | 64'sd1);
   assign w = (pol == PPID_SW_DI) ?
              (proc_i.di_gain_sel ? (64'sd1 <<< W_Q) : 64'sd0) :
              (pol == PPID_SW_AUTO) ? w_auto : 64'sd0;
   assign kp = mix(rg(IDX_KP1), rg(IDX_KP2), w);
   assign ti = mix(rg(IDX_TI1), rg(IDX_TI2), w);
   assign td = mix(rg(IDX_TD1), rg(IDX_TD2), w);

   assign p_t = (kp * err * maxf) / s64(32'(GAIN_FULL * PCT_FULL));

   // integrator counts error-ticks; a zero time is treated as 0.01 s (five steps)
   assign opt_sep = (int'(st_ff.regs[IDX_OPT]) % OPT_BASE) == 1;
   assign opt_stop = ((int'(st_ff.regs[IDX_OPT]) / OPT_BASE) % OPT_BASE) == 1;
   assign dead = abse < rg(IDX_DEAD);
   assign freeze = dead | (opt_sep & proc_i.di_int_pause)
                   | (opt_stop & st_ff.sat);
   assign acc_sum = sx(st_ff.acc) + err;
   assign acc_nx = freeze ? sx(st_ff.acc) :
                   (acc_sum > ACC_LIM) ? s64(32'(ACC_LIM)) :
                   (acc_sum < -ACC_LIM) ? -s64(32'(ACC_LIM)) : acc_sum;
   assign i_t = (acc_nx * maxf)
                / (((ti < 64'sd1) ? 64'sd1 : ti) * STEPS_PER_CS * PCT_FULL);

   // derivative on feedback so setpoint steps do not kick the output
   assign dch = rdir ? (fb_v - s64({16'h0, st_ff.fb_prev}))
                     : (s64({16'h0, st_ff.fb_prev}) - fb_v);
   assign d_raw = (dch * td * maxf) / s64(32'(TICK_MS * PCT_FULL));
   assign dlim = (rg(IDX_DCLAMP) * maxf) / s64(32'(FINE_FULL));
   assign d_t = (d_raw > dlim) ? dlim :
                (d_raw < -dlim) ? -dlim : d_raw;

   assign u = p_t + i_t + d_t;
   assign rc = rg(IDX_REV_CUT);
   assign sat_nx = (u > maxf) | (u < -rc);
   assign u_sat = (u > maxf) ? maxf :
                  (u < -rc) ? -rc : u;

   // per-step slew, limits are fractions of maximum frequency
   assign prev = sx(st_ff.out_raw);
   assign rl = (rg(IDX_RISE) * maxf) / s64(32'(FINE_FULL));
   assign fl = (rg(IDX_FALL) * maxf) / s64(32'(FINE_FULL));
   assign slw = (u_sat - prev > rl) ? prev + rl :
                (prev - u_sat > fl) ? prev - fl : u_sat;
   // inside the dead band the filter keeps settling on the held output
   assign of_nx = lpf(st_ff.out_f, (dead ? prev : slw) <<< OUT_Q,
                      st_ff.regs[IDX_OUT_FILT]);

   assign init = (rg(IDX_INIT) * maxf) / s64(32'(PCT_FULL));
   assign hlim = rg(IDX_HOLD) * STEPS_PER_CS;
   assign hold_end = s64({12'h0, st_ff.hold_cnt}) + 64'sd1 >= hlim;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = (avs_req_i.read | avs_req_i.write) & ~st_ff.ack;
      if (avs_req_i.read & ~st_ff.ack) begin
         nxt_st.rdata = rd_word;
      end
      if (avs_req_i.write & st_ff.ack & hit & (idx < 6'(NUM_RW))) begin
         if (avs_req_i.byteenable[0]) begin
            nxt_st.regs[idx][7:0] = avs_req_i.writedata[7:0];
         end
         if (avs_req_i.byteenable[1]) begin
            nxt_st.regs[idx][15:8] = avs_req_i.writedata[15:8];
         end
      end
      nxt_st.tick_cnt = tick ? 20'h0 : st_ff.tick_cnt + 20'h1;
      nxt_st.run_prev = proc_i.run;
      if (!proc_i.run) begin
         // stopped drive: next start begins cleanly from the hold
         nxt_st.holding = 1'b0;
         nxt_st.hold_cnt = 20'h0;
         nxt_st.sp_r = 32'h0;
         nxt_st.fb_f = 32'sh0;
         nxt_st.fb_prev = 16'h0;
         nxt_st.acc = 32'sh0;
         nxt_st.out_raw = 32'sh0;
         nxt_st.out_f = 32'sh0;
         nxt_st.sat = 1'b0;
      end else if (!st_ff.run_prev) begin
         nxt_st.holding = 1'b1;
         nxt_st.hold_cnt = 20'h0;
      end else if (tick) begin
         nxt_st.sp_r = 32'(sp_nx);
         nxt_st.fb_f = 32'(fb_nx);
         nxt_st.fb_prev = 16'(fb_v);
         nxt_st.sp_disp = 16'((sp_v * rg(IDX_FULL_SCALE))
                              / s64(32'(PCT_FULL)));
         nxt_st.fb_disp = 16'((fb_v * rg(IDX_FULL_SCALE))
                              / s64(32'(PCT_FULL)));
         if (st_ff.holding) begin
            nxt_st.out_raw = 32'(init);
            nxt_st.out_f = 32'(init <<< OUT_Q);
            nxt_st.hold_cnt = st_ff.hold_cnt + 20'h1;
            nxt_st.holding = ~hold_end;
         end else begin
            nxt_st.acc = 32'(acc_nx);
            nxt_st.out_f = of_nx;
            if (!dead) begin
               nxt_st.out_raw = 32'(slw);
               nxt_st.sat = sat_nx;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign freq_ref_o = st_ff.out_f >>> OUT_Q;
   assign setpoint_display_value_o = st_ff.sp_disp;
   assign feedback_display_value_o = st_ff.fb_disp;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_bus_one_wait: assert property (
      $rose(avs_req_i.read) |-> avs_rsp_o.waitrequest
                                ##1 !avs_rsp_o.waitrequest)
      else $error("read not answered after one wait state");
   a_bus_write_kp: assert property (
      avs_req_i.write && !avs_rsp_o.waitrequest && hit
      && idx == IDX_KP1 && avs_req_i.byteenable == 4'hf
      |=> st_ff.regs[IDX_KP1] == $past(avs_req_i.writedata[15:0]))
      else $error("register write lost");
   a_rev_cutoff: assert property (
      live && !dead && prev >= -rc |=> prev >= -$past(rc))
      else $error("reverse output beyond cut-off");
   a_max_sat: assert property (
      live && !dead && prev <= maxf |=> prev <= $past(maxf))
      else $error("output above maximum frequency");
   a_slew_rise: assert property (
      live |=> prev - $past(prev) <= $past(rl))
      else $error("rising step beyond limit");
   a_slew_fall: assert property (
      live |=> $past(prev) - prev <= $past(fl))
      else $error("falling step beyond limit");
   a_hold_force: assert property (
      proc_i.run && !st_ff.run_prev
      |=> st_ff.holding && st_ff.hold_cnt == 20'h0)
      else $error("start did not enter hold");
   a_hold_value: assert property (
      tick && proc_i.run && st_ff.run_prev && st_ff.holding
      |=> prev == $past(init))
      else $error("hold output not initial value");
   a_stop_clear: assert property (
      !proc_i.run |=> st_ff.acc == 0 && st_ff.out_f == 0
                      && !st_ff.holding)
      else $error("stop did not clear state");
   a_int_pause: assert property (
      live && opt_sep && proc_i.di_int_pause
      |=> st_ff.acc == $past(st_ff.acc))
      else $error("integrator ran while paused");
   a_dead_hold: assert property (
      live && dead |=> prev == $past(prev))
      else $error("output moved inside dead band");
   a_deriv_clamp: assert property (
      d_t <= dlim && d_t >= -dlim)
      else $error("derivative beyond clamp");

   c_hold_exit: cover property (
      st_ff.holding ##1 !st_ff.holding && proc_i.run);
   c_saturated: cover property (live && sat_nx);
   c_interp: cover property (
      live && pol == PPID_SW_AUTO && w > 0 && w < (64'sd1 <<< W_Q));
   c_bus_write: cover property (
      avs_req_i.write && !avs_rsp_o.waitrequest && hit);
endmodule // ppid_regulator

// ===== tb/ppid_proc_model.sv
// process-side partner: run, digital inputs, setpoint and measured feedback
`timescale 1ns/1ps
module ppid_proc_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // bench commands
   input wire ppid_pkg::ppid_proc_s cmd_i,
   input wire logic slow_i,
   // toward the regulator
   output ppid_pkg::ppid_proc_s proc_o
);
   import ppid_pkg::*;
   ppid_proc_s proc_ff;
   ppid_proc_s nxt_proc;
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_proc = cmd_i;
      // a slow plant lets the measurement creep one count per clock
      if (slow_i && proc_ff.feedback < cmd_i.feedback) begin
         nxt_proc.feedback = proc_ff.feedback + 16'h0001;
      end else if (slow_i && proc_ff.feedback > cmd_i.feedback) begin
         nxt_proc.feedback = proc_ff.feedback - 16'h0001;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         proc_ff <= '0;
      end else begin
         proc_ff <= nxt_proc;
      end
   end
   assign proc_o = proc_ff;
endmodule // ppid_proc_model

// ===== tb/tb.sv
// self-checking bench for the process regulator
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
   errors++; $display("unexpected at %0t: got %0d want %0d", $time, got, \
   exp); end end
module tb;
   import ppid_pkg::*;
   // short tick keeps the run brief; all expectations count ticks
   localparam int TK = 20;
   logic clk_i;
   logic rst_n_i;
   ppid_avs_req_s req;
   ppid_avs_rsp_s rsp;
   ppid_proc_s cmd;
   ppid_proc_s proc;
   logic slow;
   logic signed [31:0] freq;
   logic signed [31:0] v0;
   logic [15:0] sp_disp;
   logic [15:0] fb_disp;
   int errors;
   int total_checks;
   int pol [6] = '{0, 1, 1, 2, 2, 2};
   int gsel [6] = '{1, 0, 1, 0, 0, 0};
   int fbv [6] = '{700, 700, 700, 100, 900, 700};
   int lo [6] = '{0, 0, 290, 890, 0, 35};
   int hi [6] = '{8, 8, 310, 910, 8, 60};
   ////////////////////////////////////////////////////////////////////////
   ppid_regulator #(.TICK_CYCLES_P(TK)) i_ppid_regulator (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_req_i(req), .avs_rsp_o(rsp),
      .proc_i(proc), .freq_ref_o(freq),
      .setpoint_display_value_o(sp_disp),
      .feedback_display_value_o(fb_disp));
   ppid_proc_model i_ppid_proc_model (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .slow_i(slow),
      .proc_o(proc));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      req <= '{read: !wr, write: wr, address: a,
               writedata: {16'h0000, d}, byteenable: 4'hf};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 100);
      if (n >= 100) begin
         errors++;
      end
      q = rsp.readdata[15:0];
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic wreg(input logic [5:0] i, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, {i, 2'b00}, d, q);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, q);
      `CHK(q, e)
   endtask
   task automatic ticks(input int n);
      repeat (n * TK) @(posedge clk_i);
   endtask
   task automatic restart;
      cmd.run <= 1'b0;
      ticks(1);
      `CHK(freq, 32'sh0)
      cmd.run <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      give_verdict();
   end
   initial begin
      rst_n_i = 1'b0;
      req = '0;
      cmd = '0;
      slow = 1'b0;
      errors = 0;
      total_checks = 0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < NUM_RW; i++) begin
         rchk({i[5:0], 2'b00}, REG_RST[i]);
      end
      wreg(IDX_KP1, 16'h03e8);
      rchk({IDX_KP1, 2'b00}, 16'h03e8);
      wreg(IDX_OUT, 16'h1234);
      rchk({IDX_OUT, 2'b00}, 16'h0000);
      rchk(8'hfc, 16'h0000);
      rchk(8'h05, 16'h0000);
      wreg(IDX_KP1, RST_GAIN);
      // unequal slew limits tell rising from falling steps
      wreg(IDX_FALL, 16'h003c);
      cmd.setpoint <= 16'h0258;
      cmd.feedback <= 16'h012c;
      for (int k = 0; k < 4; k++) begin
         wreg(IDX_DIR, {15'h0000, k[0]});
         cmd.di_invert <= k[1];
         restart();
         ticks(3);
         v0 = freq;
         ticks(1);
         `CHK(freq - v0, (k[0] ^ k[1]) ? -32'sd30 : 32'sd50)
      end
      cmd.di_invert <= 1'b0;
      wreg(IDX_DIR, 16'h0001);
      restart();
      ticks(25);
      `CHK(freq, -32'sd200)
      wreg(IDX_DIR, 16'h0000);
      wreg(IDX_INIT, 16'h01f4);
      wreg(IDX_HOLD, 16'h0002);
      restart();
      ticks(4);
      `CHK(freq, 32'sd2500)
      ticks(4);
      `CHK(freq, 32'sd2500)
      wreg(IDX_INIT, 16'h0000);
      wreg(IDX_HOLD, 16'h0000);
      wreg(IDX_DEAD, 16'h0190);
      restart();
      ticks(10);
      `CHK(freq, 32'sh0)
      wreg(IDX_DEAD, 16'h0000);
      // open slew and slow integral expose the proportional gain alone
      wreg(IDX_RISE, 16'h2710);
      wreg(IDX_FALL, 16'h2710);
      wreg(IDX_TI1, 16'h03e8);
      wreg(IDX_TI2, 16'h03e8);
      wreg(IDX_KP1, 16'h0000);
      cmd.setpoint <= 16'h03e8;
      // thresholds stay at 200 and 800, the low one below the high
      for (int r = 0; r < 6; r++) begin
         wreg(IDX_POLICY, pol[r][15:0]);
         cmd.di_gain_sel <= gsel[r][0];
         cmd.feedback <= fbv[r][15:0];
         restart();
         ticks(3);
         `CHK((freq >= lo[r] && freq <= hi[r]), 1'b1)
      end
      // fast integral alone: paused it stays at zero, with separation off it climbs
      wreg(IDX_POLICY, 16'h0000);
      wreg(IDX_TI1, 16'h0001);
      wreg(IDX_OPT, 16'h0001);
      cmd.di_int_pause <= 1'b1;
      restart();
      ticks(4);
      `CHK(freq, 32'sh0)
      wreg(IDX_OPT, 16'h0000);
      restart();
      ticks(4);
      `CHK((freq > 0), 1'b1)
      cmd.di_int_pause <= 1'b0;
      wreg(IDX_FULL_SCALE, 16'h07d0);
      slow <= 1'b1;
      cmd.feedback <= 16'h01f4;
      restart();
      ticks(40);
      `CHK(sp_disp, 16'h07d0)
      `CHK(fb_disp, 16'h03e8)
      wreg(IDX_RAMP, 16'h0064);
      wreg(IDX_FB_FILT, 16'h0064);
      restart();
      ticks(50);
      `CHK((sp_disp >= 16'h00b4 && sp_disp <= 16'h00d2), 1'b1)
      `CHK((fb_disp > 16'h0000 && fb_disp < 16'h00c8), 1'b1)
      give_verdict();
   end
endmodule // tb
